// *** bench/ldb_chk.sv ***
`timescale 1ns/10ps
// port-level checks of loop entry, exit and answers
module ldb_chk (
    input wire logic         clk,
    input wire logic         srst,
    input wire logic         br_valid,
    input ldb_pkg::ldb_req_s br_req,
    input wire logic         irq_pending,
    input wire logic         trace_en,
    input wire logic         fetch_en,
    input wire logic         loop_active,
    input wire logic         op_issue,
    input wire logic [15:0]  op_word,
    input wire logic         res_valid,
    input ldb_pkg::ldb_res_s res
);
    // one domain, so one default clock and reset
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    property p_no_fetch; loop_active || op_issue |-> loop_active && !fetch_en; endproperty
    a_no_fetch: assert property (p_no_fetch) else $error("fetch allowed in loop");
    property p_answer; br_valid && !loop_active |=> res_valid; endproperty
    a_answer: assert property (p_answer) else $error("branch not answered");
    property p_entry; $rose(loop_active) |-> $past(br_valid) && $past(br_req.disp) == 16'hfffc
        && $past(br_req.prev_loopable); endproperty
    a_entry: assert property (p_entry) else $error("bad loop entry");
    property p_hold; $rose(loop_active) |-> op_issue && op_word == $past(br_req.prev_word); endproperty
    a_hold: assert property (p_hold) else $error("op not held");
    property p_no_irq; $rose(loop_active) |-> !$past(irq_pending); endproperty
    a_no_irq: assert property (p_no_irq) else $error("loop entered with irq");
    property p_no_trace; $rose(loop_active) |-> !$past(trace_en); endproperty
    a_no_trace: assert property (p_no_trace) else $error("loop entered while tracing");
    property p_exhaust; res_valid |-> (res.count == 16'hffff) == (res.count_we && !res.taken); endproperty
    a_exhaust: assert property (p_exhaust) else $error("bad exhausted count");
    property p_exit; res_valid && !res.taken |-> !loop_active && fetch_en; endproperty
    a_exit: assert property (p_exit) else $error("loop kept on fall through");
    property p_taken; res_valid && res.taken |-> res.count != 16'hffff; endproperty
    a_taken: assert property (p_taken) else $error("branch on minus one");
    c_enter: cover property ($rose(loop_active));
    c_leave: cover property ($fell(loop_active));
    c_fall: cover property (res_valid && !res.taken);
endmodule

// *** bench/loop_mode_branch_control_tb.sv ***
`timescale 1ns/10ps
module loop_mode_branch_control_tb;
    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic              br_valid = 1'b0;
    ldb_pkg::ldb_req_s br_req = '0;
    logic              op_done = 1'b0;
    logic              irq_pending = 1'b0;
    logic              trace_en = 1'b0;
    logic              bus_error = 1'b0;
    logic              fetch_en, loop_active, op_issue, res_valid, irq_take, trace_take;
    logic [15:0]       op_word;
    ldb_pkg::ldb_res_s res;
    int                failures = 0;
    int                total_checks = 0;

    // 100 ns period
    always #50 clk = ~clk;

    ldb_ctrl DUT (.clk, .srst, .br_valid, .br_req, .op_done, .irq_pending, .trace_en, .bus_error,
        .fetch_en, .loop_active, .op_issue, .op_word, .res_valid, .res, .irq_take, .trace_take);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    // branch at pc 100; waits an edge first so br_valid is never set twice at once
    task automatic br(input logic [15:0] disp, input logic [3:0] cond, input logic [15:0] cnt, input logic lp);
        @(negedge clk);
        br_req.pc            = 32'h0000_0100;
        br_req.disp          = disp;
        br_req.cond          = cond;
        br_req.count         = cnt;
        br_req.ccr           = 4'h0;
        br_req.prev_loopable = lp;
        br_req.prev_word     = 16'h3098;
        br_valid = 1'b1;
        @(negedge clk);
        br_valid = 1'b0;
    endtask

    // looped op completes; the answer shows two edges later
    task automatic op();
        @(negedge clk);
        op_done = 1'b1;
        @(negedge clk);
        op_done = 1'b0;
        @(negedge clk);
    endtask

    task automatic t_plain();
        br(16'h0010, 4'h1, 16'h0005, 1'b0);
        check({res_valid, res.taken}, 2'b11);
        check(res.next_pc, 32'h0000_0112);
        check(res.count, 16'h0004);
        br(16'h0010, 4'h0, 16'h0005, 1'b0);
        check({res.taken, res.count_we}, 2'b00);
        check(res.next_pc, 32'h0000_0104);
        // minus one wins over a true condition
        br(16'h0010, 4'h0, 16'h0000, 1'b0);
        check({res.taken, res.count_we, res.count}, {2'b01, 16'hffff});
    endtask

    task automatic t_loop();
        br(16'hfffc, 4'h1, 16'h0002, 1'b1);
        check({loop_active, fetch_en, op_issue}, 3'b101);
        check(op_word, 16'h3098);
        check(res.next_pc, 32'h0000_00fe);
        op();
        check({res_valid, res.taken, op_issue, res.count}, {3'b111, 16'h0000});
        check({loop_active, fetch_en}, 2'b10);
        op();
        check({res.count_we, res.count, loop_active, fetch_en}, {1'b1, 16'hffff, 2'b01});
    endtask

    task automatic t_abort();
        trace_en = 1'b1;
        br(16'hfffc, 4'h1, 16'h0005, 1'b1);
        check({res.taken, loop_active, trace_take}, 3'b101);
        trace_en = 1'b0;
        irq_pending = 1'b1;
        br(16'hfffc, 4'h1, 16'h0005, 1'b1);
        check({res.taken, loop_active, irq_take}, 3'b101);
        irq_pending = 1'b0;
        br(16'hfffc, 4'h1, 16'h0005, 1'b1);
        check(loop_active, 1'b1);
        // interrupt waits for the branch, then ends the loop
        irq_pending = 1'b1;
        @(negedge clk);
        check({irq_take, loop_active}, 2'b01);
        op();
        check({irq_take, loop_active, fetch_en}, 3'b101);
        irq_pending = 1'b0;
    endtask

    // a bus error in the op phase drops loop mode and restores fetches
    task automatic t_bus_err();
        br(16'hfffc, 4'h1, 16'h0005, 1'b1);
        check(loop_active, 1'b1);
        bus_error = 1'b1;
        @(negedge clk);
        bus_error = 1'b0;
        check({loop_active, fetch_en, irq_take}, 3'b010);
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // reset for three edges, then the scenarios
    initial begin
        repeat (3) @(negedge clk);
        srst = 1'b0;
        check({fetch_en, loop_active}, 2'b10);
        t_plain();
        t_loop();
        t_abort();
        t_bus_err();
        end_of_test();
    end

    // hang guard, far beyond the scenario length
    initial begin
        repeat (2000) @(posedge clk);
        failures++;
        end_of_test();
    end
endmodule

bind ldb_ctrl ldb_chk u_chk (.clk, .srst, .br_valid, .br_req, .irq_pending, .trace_en, .fetch_en,
    .loop_active, .op_issue, .op_word, .res_valid, .res);

// *** core/ldb_ctrl.sv ***
`timescale 1ns/10ps
`include "ldb_defs.svh"

module ldb_ctrl (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              br_valid,     // decoder presents a branch
    input  ldb_pkg::ldb_req_s      br_req,
    input  wire logic              op_done,      // looped op finished its operands
    input  wire logic              irq_pending,
    input  wire logic              trace_en,
    input  wire logic              bus_error,
    output logic                   fetch_en,     // instruction fetches allowed
    output logic                   loop_active,
    output logic                   op_issue,     // replay held op this cycle
    output logic [15:0]            op_word,      // held decode register
    output logic                   res_valid,
    output ldb_pkg::ldb_res_s      res,
    output logic                   irq_take,
    output logic                   trace_take
);

    ldb_pkg::ldb_state_e state;
    ldb_pkg::ldb_state_e next_state;
    ldb_pkg::ldb_req_s   held;       // prefetch queue copy of the branch
    ldb_pkg::ldb_req_s   cur_req;
    ldb_pkg::ldb_res_s   cur_res;
    logic [15:0]         live_count;

    // state decodes shared by the control terms and the registers
    wire in_idle  = state == ldb_pkg::LDB_IDLE;
    wire in_op    = state == ldb_pkg::LDB_LOOP_OP;
    wire in_br    = state == ldb_pkg::LDB_LOOP_BR;
    wire go_idle  = next_state == ldb_pkg::LDB_IDLE;
    wire go_op    = next_state == ldb_pkg::LDB_LOOP_OP;
    wire entering = in_idle && go_op;

    // in loop mode the branch reads the live count, not the decoder's stale copy
    always_comb begin
        cur_req = (state == ldb_pkg::LDB_LOOP_BR) ? held : br_req;
        if (state == ldb_pkg::LDB_LOOP_BR) begin
            cur_req.count = live_count;
        end
    end

    ldb_eval u_eval (
        .req (cur_req),
        .res (cur_res)
    );

    // evaluation happens on decoder request or on each loop-mode branch pass
    wire eval_now  = (state == ldb_pkg::LDB_IDLE && br_valid) ||
                     state == ldb_pkg::LDB_LOOP_BR;
    wire disp_ok   = br_req.disp == `LDB_LOOP_DISP;
    // the loop op itself must be the one-word instruction right before us
    wire can_enter = br_valid && cur_res.taken && disp_ok &&
                     br_req.prev_loopable && !trace_en;
    // interrupt is only looked at on a branch boundary
    wire irq_now   = eval_now && irq_pending;
    wire trace_now = trace_en && (eval_now || (state == ldb_pkg::LDB_LOOP_OP && op_done));
    // reasons to leave loop mode; the op phase ignores interrupts on purpose
    wire op_abort  = bus_error || trace_en;
    wire br_stop   = !cur_res.taken || irq_now || trace_en || bus_error;

    // next state choice
    always_comb begin
        next_state = state;
        case (state)
            ldb_pkg::LDB_IDLE: begin
                if (can_enter && !irq_now) begin
                    next_state = ldb_pkg::LDB_LOOP_OP;
                end
            end
            ldb_pkg::LDB_LOOP_OP: begin
                // op is never interrupted mid-loop; only bus error or trace exits
                if (op_abort) begin
                    next_state = ldb_pkg::LDB_IDLE;
                end else if (op_done) begin
                    next_state = ldb_pkg::LDB_LOOP_BR;
                end
            end
            default: begin
                if (br_stop) begin
                    next_state = ldb_pkg::LDB_IDLE;
                end else begin
                    next_state = ldb_pkg::LDB_LOOP_OP;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ldb_pkg::LDB_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // prefetch queue copy of the branch, caught on a real entry only
    always_ff @(posedge clk) begin
        if (srst) begin
            held <= '0;
        end else if (entering) begin
            held <= br_req;
        end
    end

    // live counter word; the decoder's copy goes stale once fetches stop
    always_ff @(posedge clk) begin
        if (srst) begin
            live_count <= `LDB_WORD_RST;
        end else if (entering || (in_br && cur_res.count_we)) begin
            live_count <= cur_res.count;
        end
    end

    // decode register keeps the looped op for every replay
    always_ff @(posedge clk) begin
        if (srst) begin
            op_word <= `LDB_WORD_RST;
        end else if (entering) begin
            op_word <= br_req.prev_word;
        end
    end

    // fetches stop from the entry edge until the loop ends
    always_ff @(posedge clk) begin
        if (srst) begin
            fetch_en    <= `LDB_FETCH_RST;
            loop_active <= 1'b0;
        end else begin
            fetch_en    <= go_idle;
            loop_active <= !go_idle;
        end
    end

    // one replay strobe per pass, on the edge that enters the op phase
    always_ff @(posedge clk) begin
        if (srst) begin
            op_issue <= 1'b0;
        end else begin
            op_issue <= go_op && !in_op;
        end
    end

    // the answer stands for one cycle after each evaluating edge
    always_ff @(posedge clk) begin
        if (srst) begin
            res_valid <= 1'b0;
            res       <= '0;
        end else begin
            res_valid <= eval_now;
            res       <= cur_res;
        end
    end

    // exception strobes, one cycle each
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_take   <= 1'b0;
            trace_take <= 1'b0;
        end else begin
            irq_take   <= irq_now;
            trace_take <= trace_now;
        end
    end

endmodule

// *** core/ldb_defs.svh ***
`ifndef LDB_DEFS_SVH
`define LDB_DEFS_SVH

// counter word limits
`define LDB_CNT_W        16
`define LDB_CNT_ALL_ONES 16'hffff
// loop displacement of minus four
`define LDB_LOOP_DISP    16'hfffc
// condition field width
`define LDB_COND_W       4
// condition code bit positions
`define LDB_CCR_C        0
`define LDB_CCR_V        1
`define LDB_CCR_Z        2
`define LDB_CCR_N        3
// address width and instruction word size in bytes
`define LDB_ADDR_W       32
`define LDB_WORD_BYTES   32'h0000_0002
// branch instruction length in bytes
`define LDB_BR_BYTES     32'h0000_0004
// reset values of the fetch gate and of the held words
`define LDB_FETCH_RST    1'b1
`define LDB_WORD_RST     16'h0000

`endif

// *** core/ldb_eval.sv ***
`timescale 1ns/10ps
`include "ldb_defs.svh"

// combinational evaluation of one test_decrement_branch
module ldb_eval (
    input  ldb_pkg::ldb_req_s req,
    output ldb_pkg::ldb_res_s res
);

    // condition test over n z v c
    function automatic logic cond_true(input logic [3:0] cc, input logic [3:0] ccr);
        logic n;
        logic z;
        logic v;
        logic c;
        n = ccr[`LDB_CCR_N];
        z = ccr[`LDB_CCR_Z];
        v = ccr[`LDB_CCR_V];
        c = ccr[`LDB_CCR_C];
        case (cc)
            4'h0: cond_true = 1'b1;
            4'h1: cond_true = 1'b0;
            4'h2: cond_true = !c && !z;
            4'h3: cond_true = c || z;
            4'h4: cond_true = !c;
            4'h5: cond_true = c;
            4'h6: cond_true = !z;
            4'h7: cond_true = z;
            4'h8: cond_true = !v;
            4'h9: cond_true = v;
            4'ha: cond_true = !n;
            4'hb: cond_true = n;
            4'hc: cond_true = n == v;
            4'hd: cond_true = n != v;
            4'he: cond_true = !z && (n == v);
            default: cond_true = z || (n != v);
        endcase
    endfunction

    wire [15:0] dec_count = req.count - 16'h0001;
    wire        exhausted = dec_count == `LDB_CNT_ALL_ONES;
    wire        cc_ok     = cond_true(req.cond, req.ccr);
    wire [31:0] disp_ext  = {{16{req.disp[15]}}, req.disp};
    wire [31:0] fall_pc   = req.pc + `LDB_BR_BYTES;
    wire [31:0] jump_pc   = req.pc + `LDB_WORD_BYTES + disp_ext;

    // minus one is tested first; only then does a true condition discard the count
    assign res.taken    = !cc_ok && !exhausted;
    assign res.count_we = exhausted || !cc_ok;
    assign res.count    = dec_count;
    assign res.next_pc  = res.taken ? jump_pc : fall_pc;

endmodule

// *** core/ldb_pkg.sv ***
package ldb_pkg;

    // one decrement-and-branch request from the decoder
    typedef struct packed {
        logic [31:0] pc;          // address of the branch opcode word
        logic [15:0] disp;        // branch displacement
        logic [3:0]  cond;        // condition selector
        logic [15:0] count;       // low word of the counter register
        logic [3:0]  ccr;         // n z v c
        logic        prev_loopable; // preceding instruction is a one-word loop op
        logic [15:0] prev_word;   // opcode of the preceding instruction
    } ldb_req_s;

    // evaluation result
    typedef struct packed {
        logic [31:0] next_pc;
        logic [15:0] count;
        logic        count_we;
        logic        taken;
    } ldb_res_s;

    typedef enum logic [1:0] {
        LDB_IDLE,
        LDB_LOOP_OP,
        LDB_LOOP_BR
    } ldb_state_e;

endpackage
